/* rtl/wrs_pkg.sv */
// constants and types shared by the watchdog reset supervisor
`default_nettype none
package wrs_pkg;
	// clock
	localparam int unsigned CLK_PERIOD_NS   = 10;

	// nominal watchdog timeout and derived cycle counts
	localparam int unsigned WDT_TIMEOUT_NS  = 1600000000;
	localparam int unsigned WDT_CYC         = WDT_TIMEOUT_NS / CLK_PERIOD_NS;

	// minimum reset timeout, rounded up to whole cycles
	localparam int unsigned RST_TIMEOUT_NS  = 140000000;
	localparam int unsigned RST_CYC         = (RST_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// shortest strobe pulse to be caught; it spans five cycles of sampling
	localparam int unsigned STROBE_MIN_NS   = 50;
	localparam int unsigned STROBE_MIN_CYC  = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// weak drive pattern: low for 7/8 of the period, high for the last 1/8
	localparam int unsigned WEAK_NUM        = 7;
	localparam int unsigned WEAK_DEN        = 8;

	// counter width, wide enough for the watchdog period
	localparam int unsigned CNT_W           = 28;

	// values after reset
	localparam logic        SYNC_RST        = 1'b0;
	localparam logic        MR_SYNC_RST     = 1'b1;
	localparam logic [CNT_W-1:0] CNT_RST    = 28'h0000000;

	// supervisor states, gray along run -> hold -> pulse
	typedef enum logic [1:0]
	{
		WRS_RUN   = 2'b00,
		WRS_HOLD  = 2'b01,
		WRS_PULSE = 2'b11
	} wrs_state_e;

	// cause of the last reset pulse
	typedef enum logic [1:0]
	{
		WRS_CAUSE_NONE   = 2'b00,
		WRS_CAUSE_POWER  = 2'b01,
		WRS_CAUSE_MANUAL = 2'b10,
		WRS_CAUSE_WDT    = 2'b11
	} wrs_cause_e;
endpackage
`default_nettype wire

/* rtl/wrs_cnt_if.sv */
// carrier between the supervisor and its period counter
`timescale 1ns/1ps
`default_nettype none
interface wrs_cnt_if;
	logic                      clr;
	logic                      run;
	logic [wrs_pkg::CNT_W-1:0] count;

	modport ctl
	(
		output clr,
		output run,
		input  count
	);

	modport cnt
	(
		input  clr,
		input  run,
		output count
	);
endinterface
`default_nettype wire

/* rtl/wrs_counter.sv */
// clearable period counter used as the watchdog timer
`timescale 1ns/1ps
`default_nettype none
module wrs_counter
(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// control and count
	wrs_cnt_if.cnt    cnt_if
);
	logic [wrs_pkg::CNT_W-1:0] count_q;
	logic [wrs_pkg::CNT_W-1:0] count_d;

	// clear beats run
	always_comb
	begin
		count_d = count_q;
		if (cnt_if.clr)
		begin
			count_d = wrs_pkg::CNT_RST;
		end
		else if (cnt_if.run)
		begin
			count_d = count_q + 28'h0000001;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			count_q <= wrs_pkg::CNT_RST;
		end
		else
		begin
			count_q <= count_d;
		end
	end

	assign cnt_if.count = count_q;
endmodule
`default_nettype wire

/* rtl/wrs_watchdog_reset_supervisor.sv */
// watchdog timer and reset pulse logic of the processor supervisor
`timescale 1ns/1ps
`default_nettype none
module wrs_watchdog_reset_supervisor
#(
	parameter int unsigned WDT_CYC = wrs_pkg::WDT_CYC,
	parameter int unsigned RST_CYC = wrs_pkg::RST_CYC
)
(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// watchdog strobe pin
	input  wire logic watchdog_strobe_in,
	output var  logic watchdog_strobe_out,
	output var  logic watchdog_strobe_oe,
	// manual reset pin
	input  wire logic manual_reset_n,
	// reset outputs
	output var  logic reset_out,
	output var  logic reset_out_n,
	output var  logic reset_out_n_oe,
	// status
	output var  logic [1:0] reset_cause
);
	// thresholds at counter width
	localparam logic [wrs_pkg::CNT_W-1:0] WDT_LAST  = wrs_pkg::CNT_W'(WDT_CYC - 1);
	localparam logic [wrs_pkg::CNT_W-1:0] WEAK_HIGH =
		wrs_pkg::CNT_W'((WDT_CYC / wrs_pkg::WEAK_DEN) * wrs_pkg::WEAK_NUM);
	localparam logic [wrs_pkg::CNT_W-1:0] RST_LAST  = wrs_pkg::CNT_W'(RST_CYC - 1);

	// pin synchronisers and edge history
	logic strobe_s1_q;
	logic strobe_s2_q;
	logic strobe_prev_q;
	logic mr_s1_q;
	logic mr_s2_q;
	logic strobe_edge;

	// supervisor state
	wrs_pkg::wrs_state_e state_q;
	wrs_pkg::wrs_state_e state_d;
	logic [wrs_pkg::CNT_W-1:0] pulse_q;
	logic [wrs_pkg::CNT_W-1:0] pulse_d;
	wrs_pkg::wrs_cause_e cause_q;
	wrs_pkg::wrs_cause_e cause_d;

	// registered outputs
	logic rst_q;
	logic rst_d;
	logic weak_q;
	logic weak_d;
	logic weak_oe_q;

	// watchdog timer
	wrs_cnt_if wdt_if ();
	logic wdt_expired;
	logic mr_active;

	wrs_counter u_wdt
	(
		.ref_clk (ref_clk),
		.reset   (reset),
		.cnt_if  (wdt_if)
	);

	// every cycle samples the pin, so a 50 ns pulse spans several samples
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			strobe_s1_q   <= wrs_pkg::SYNC_RST;
			strobe_s2_q   <= wrs_pkg::SYNC_RST;
			strobe_prev_q <= wrs_pkg::SYNC_RST;
			mr_s1_q       <= wrs_pkg::MR_SYNC_RST;
			mr_s2_q       <= wrs_pkg::MR_SYNC_RST;
		end
		else
		begin
			strobe_s1_q   <= watchdog_strobe_in;
			strobe_s2_q   <= strobe_s1_q;
			strobe_prev_q <= strobe_s2_q;
			mr_s1_q       <= manual_reset_n;
			mr_s2_q       <= mr_s1_q;
		end
	end

	// either polarity counts
	assign strobe_edge = strobe_s2_q ^ strobe_prev_q;
	assign mr_active   = ~mr_s2_q;
	assign wdt_expired = (wdt_if.count == WDT_LAST);

	// counter runs only outside reset and restarts from zero on release
	always_comb
	begin
		wdt_if.clr = strobe_edge | mr_active | (state_q != wrs_pkg::WRS_RUN) | wdt_expired;
		wdt_if.run = (state_q == wrs_pkg::WRS_RUN);
	end

	// supervisor sequencing
	always_comb
	begin
		state_d = state_q;
		pulse_d = pulse_q;
		cause_d = cause_q;
		case (state_q)
			wrs_pkg::WRS_RUN:
			begin
				pulse_d = wrs_pkg::CNT_RST;
				if (mr_active)
				begin
					state_d = wrs_pkg::WRS_HOLD;
					cause_d = wrs_pkg::WRS_CAUSE_MANUAL;
				end
				else if (wdt_expired)
				begin
					state_d = wrs_pkg::WRS_PULSE;
					cause_d = wrs_pkg::WRS_CAUSE_WDT;
				end
			end
			wrs_pkg::WRS_HOLD:
			begin
				pulse_d = wrs_pkg::CNT_RST;
				if (!mr_active)
				begin
					state_d = wrs_pkg::WRS_PULSE;
				end
			end
			wrs_pkg::WRS_PULSE:
			begin
				if (mr_active)
				begin
					state_d = wrs_pkg::WRS_HOLD;
					pulse_d = wrs_pkg::CNT_RST;
					cause_d = wrs_pkg::WRS_CAUSE_MANUAL;
				end
				else if (pulse_q == RST_LAST)
				begin
					state_d = wrs_pkg::WRS_RUN;
					pulse_d = wrs_pkg::CNT_RST;
				end
				else
				begin
					pulse_d = pulse_q + 28'h0000001;
				end
			end
			default:
			begin
				state_d = wrs_pkg::WRS_PULSE;
				pulse_d = wrs_pkg::CNT_RST;
			end
		endcase
	end

	// power-up starts with one full reset pulse
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_q <= wrs_pkg::WRS_PULSE;
			pulse_q <= wrs_pkg::CNT_RST;
			cause_q <= wrs_pkg::WRS_CAUSE_POWER;
		end
		else
		begin
			state_q <= state_d;
			pulse_q <= pulse_d;
			cause_q <= cause_d;
		end
	end

	// output drive, computed from next state so outputs follow without lag
	always_comb
	begin
		rst_d  = (state_d != wrs_pkg::WRS_RUN);
		// high phase only while counting; reset forces the low phase
		weak_d = (state_d == wrs_pkg::WRS_RUN) && !wdt_if.clr && (wdt_if.count >= WEAK_HIGH);
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			rst_q     <= 1'b1;
			weak_q    <= 1'b0;
			weak_oe_q <= 1'b0;
		end
		else
		begin
			rst_q     <= rst_d;
			weak_q    <= weak_d;
			weak_oe_q <= 1'b1;
		end
	end

	// weak driver: an external driver overrides it at the pin
	assign watchdog_strobe_out = weak_q;
	assign watchdog_strobe_oe  = weak_oe_q;

	// open-drain: drive low only while asserting, release otherwise
	assign reset_out      = rst_q;
	assign reset_out_n    = ~rst_q & 1'b0;
	assign reset_out_n_oe = rst_q;
	assign reset_cause    = cause_q;
endmodule
`default_nettype wire

/* dv/wrs_sva.sv */
// port assertions for the watchdog reset supervisor
`timescale 1ns/1ps
`default_nettype none
module wrs_sva
#(
	parameter int unsigned WDT_CYC = 400,
	parameter int unsigned RST_CYC = 50
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// pins
	input wire logic watchdog_strobe_in,
	input wire logic watchdog_strobe_out,
	input wire logic manual_reset_n,
	input wire logic reset_out,
	input wire logic reset_out_n,
	input wire logic reset_out_n_oe
);
	localparam int T7 = (WDT_CYC / 8) * 7;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// idle: cycles since a pin edge; hi: reset high; mh: manual released
	logic last_q;
	logic last_d;
	int   idle_q;
	int   idle_d;
	int   hi_q;
	int   hi_d;
	int   mh_q;
	int   mh_d;
	always_comb
	begin
		last_d = watchdog_strobe_in;
		idle_d = (reset || reset_out || !manual_reset_n || watchdog_strobe_in != last_q) ? 0 : idle_q + 1;
		hi_d = (!reset && reset_out) ? hi_q + 1 : 0;
		mh_d = (!reset && manual_reset_n) ? mh_q + 1 : 0;
	end
	always_ff @(posedge ref_clk)
	begin
		last_q <= last_d;
		idle_q <= idle_d;
		hi_q <= hi_d;
		mh_q <= mh_d;
	end
	sequence wdt_fire;
		$rose(reset_out) && manual_reset_n;
	endsequence
	sequence held;
		reset_out [*3];
	endsequence
	a_od_enable: assert property (reset_out_n_oe == reset_out) else $error("open drain enable wrong");
	a_od_level: assert property (reset_out_n == 1'b0) else $error("open drain level high");
	a_fire_bound: assert property (idle_q <= WDT_CYC + 8) else $error("watchdog did not fire");
	a_early_fire: assert property (wdt_fire |-> idle_q >= WDT_CYC - 4) else $error("watchdog fired early");
	a_pulse_len: assert property ($fell(reset_out) |-> hi_q >= RST_CYC - 1) else $error("reset pulse short");
	a_pulse_max: assert property (hi_q > RST_CYC + 4 |-> mh_q < RST_CYC + 4) else $error("reset pulse long");
	a_strobe_quiet: assert property (held |-> !watchdog_strobe_out) else $error("weak drive high in reset");
	a_strobe_onset: assert property ($rose(watchdog_strobe_out) |-> idle_q >= T7 - 2 && idle_q <= T7 + 8)
		else $error("weak drive high at wrong time");
endmodule
`default_nettype wire

/* dv/wrs_mcu_model.sv */
// processor model serving the watchdog strobe pin
`timescale 1ns/1ps
`default_nettype none
module wrs_mcu_model
#(
	parameter int PERIOD = 200
)
(
	// clock
	input  wire logic       ref_clk,
	// 0 released, 1 pulsing, 2 hung low
	input  wire logic [1:0] mode,
	// pin drive
	output var  logic       drv,
	output var  logic       drv_oe
);
	// int starts at zero, so no initialiser beside the clocked writer
	int t_q;
	always_ff @(posedge ref_clk)
	begin
		t_q <= (t_q >= PERIOD - 1) ? 0 : t_q + 1;
		drv_oe <= (mode != 2'h0);
		drv <= (mode == 2'h1) && (t_q < 5);
	end
endmodule
`default_nettype wire

/* dv/wrs_watchdog_reset_supervisor_bench.sv */
// self-checking bench of the watchdog reset supervisor
`timescale 1ns/1ps
`default_nettype none
module wrs_watchdog_reset_supervisor_bench;
	localparam int WDT = 400;
	localparam int RST = 50;
	logic       ref_clk = 1'b0;
	logic       reset = 1'b1;
	logic       mr_n = 1'b1;
	logic [1:0] mode = 2'h0;
	logic       pin;
	logic       s_out;
	logic       s_oe;
	logic       r_out;
	logic [1:0] cause;
	logic       m_drv;
	logic       m_oe;
	int         n_errors = 0;
	int         checked = 0;
	int         cyc = 0;
	int         n;
	int         k;
	always #5 ref_clk = ~ref_clk;
	// released pin shows the inverse rather than a stale level
	assign pin = m_oe ? m_drv : (s_oe ? s_out : ~s_out);
	wrs_watchdog_reset_supervisor #(.WDT_CYC(WDT), .RST_CYC(RST)) wrs_watchdog_reset_supervisor_inst
	(
		.ref_clk(ref_clk), .reset(reset), .watchdog_strobe_in(pin), .watchdog_strobe_out(s_out),
		.watchdog_strobe_oe(s_oe), .manual_reset_n(mr_n), .reset_out(r_out), .reset_out_n(),
		.reset_out_n_oe(), .reset_cause(cause)
	);
	wrs_mcu_model #(.PERIOD(200)) wrs_mcu_model_inst (.ref_clk(ref_clk), .mode(mode), .drv(m_drv), .drv_oe(m_oe));
	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// full width so a count is never truncated before the compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic span(input logic v, input int lim);
		n = 0;
		while (r_out !== v && n < lim)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask
	// reset must stay low; counts weak drive rises
	task automatic quiet(input int c);
		logic bad;
		logic prev;
		bad = 1'b0;
		k = 0;
		prev = s_out;
		repeat (c)
		begin
			@(posedge ref_clk);
			#1;
			bad |= r_out;
			k += int'(s_out & ~prev);
			prev = s_out;
		end
		chk(bad, 1'b0);
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk(cause, wrs_pkg::WRS_CAUSE_POWER);
		chk(s_oe, 1'b1);
		span(1'b0, RST + 10);
		chk(n >= RST - 2 && n <= RST + 2, 1'b1);
		quiet(3 * WDT);
		chk(k >= 3, 1'b1);
		@(posedge ref_clk) mode <= 2'h1;
		quiet(3 * WDT);
		chk(k, 0);
		@(posedge ref_clk) mode <= 2'h2;
		span(1'b1, WDT + 20);
		chk(cause, wrs_pkg::WRS_CAUSE_WDT);
		span(1'b0, RST + 10);
		chk(n >= RST - 1 && n <= RST + 1, 1'b1);
		quiet(WDT - 10);
		span(1'b1, 30);
		chk(r_out, 1'b1);
		chk(n >= 9 && n <= 11, 1'b1);
		@(posedge ref_clk) mode <= 2'h1;
		span(1'b0, RST + 10);
		@(posedge ref_clk) mr_n <= 1'b0;
		span(1'b1, 6);
		chk(cause, wrs_pkg::WRS_CAUSE_MANUAL);
		repeat (100) @(posedge ref_clk);
		mr_n <= 1'b1;
		#1;
		span(1'b0, RST + 20);
		chk(n >= RST && n <= RST + 6, 1'b1);
		quiet(WDT);
		give_verdict();
	end
endmodule
bind wrs_watchdog_reset_supervisor wrs_sva #(.WDT_CYC(WDT_CYC), .RST_CYC(RST_CYC)) wrs_sva_inst
(
	.ref_clk(ref_clk), .reset(reset), .watchdog_strobe_in(watchdog_strobe_in),
	.watchdog_strobe_out(watchdog_strobe_out), .manual_reset_n(manual_reset_n), .reset_out(reset_out),
	.reset_out_n(reset_out_n), .reset_out_n_oe(reset_out_n_oe)
);
`default_nettype wire
